// ==== core/rss_axil_slave.sv ====
// AXI4-Lite slave front end with single-cycle register strobes
module rss_axil_slave
   import rss_pkg::*;
(
   input wire logic mclk_i, // System clock
   input wire logic sys_rst_i, // Async reset, high
   input wire logic [11:0] s_awaddr_i, // Write address
   input wire logic s_awvalid_i, // Write address valid
   output logic s_awready_o, // Write address ready
   input wire logic [31:0] s_wdata_i, // Write data
   input wire logic [3:0] s_wstrb_i, // Write byte enables
   input wire logic s_wvalid_i, // Write data valid
   output logic s_wready_o, // Write data ready
   output logic [1:0] s_bresp_o, // Write response
   output logic s_bvalid_o, // Write response valid
   input wire logic s_bready_i, // Write response ready
   input wire logic [11:0] s_araddr_i, // Read address
   input wire logic s_arvalid_i, // Read address valid
   output logic s_arready_o, // Read address ready
   output logic [31:0] s_rdata_o, // Read data
   output logic [1:0] s_rresp_o, // Read response
   output logic s_rvalid_o, // Read data valid
   input wire logic s_rready_i, // Read data ready
   output logic wr_en_o, // Register write strobe
   output logic [11:0] wr_addr_o, // Register write address
   output logic [31:0] wr_data_o, // Register write data
   output logic [3:0] wr_strb_o, // Register write enables
   input wire logic wr_hit_i, // Write address is mapped
   output logic [11:0] rd_addr_o, // Read decode address
   input wire logic [31:0] rd_data_i, // Read decode data
   input wire logic rd_hit_i // Read address is mapped
);

   // ----------------------------------------
   // Holding registers
   // ----------------------------------------
   logic aw_full_r; // Address waiting
   logic w_full_r; // Data waiting
   logic bvalid_r; // Write answer pending
   logic rvalid_r; // Read answer pending
   logic [11:0] awaddr_r; // Held address
   logic [31:0] wdata_r; // Held data
   logic [3:0] wstrb_r; // Held enables
   logic [31:0] rdata_r; // Read answer data
   rss_resp_t bresp_r; // Write answer code
   rss_resp_t rresp_r; // Read answer code

   // Handshake decode
   wire aw_take = s_awvalid_i & s_awready_o;
   wire w_take = s_wvalid_i & s_wready_o;
   wire ar_take = s_arvalid_i & s_arready_o;
   wire wr_go = aw_full_r & w_full_r & ~bvalid_r;

   assign s_awready_o = ~aw_full_r & ~bvalid_r;
   assign s_wready_o = ~w_full_r & ~bvalid_r;
   assign s_arready_o = ~rvalid_r;
   assign s_bvalid_o = bvalid_r;
   assign s_bresp_o = bresp_r;
   assign s_rvalid_o = rvalid_r;
   assign s_rdata_o = rdata_r;
   assign s_rresp_o = rresp_r;
   assign wr_en_o = wr_go;
   assign wr_addr_o = awaddr_r;
   assign wr_data_o = wdata_r;
   assign wr_strb_o = wstrb_r;
   assign rd_addr_o = s_araddr_i;

   // Write channel capture, in either order
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         awaddr_r <= 12'h000;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end
      else
      begin
         aw_full_r <= (aw_full_r | aw_take) & ~wr_go;
         w_full_r <= (w_full_r | w_take) & ~wr_go;
         if (aw_take)
            awaddr_r <= s_awaddr_i;
         if (w_take)
         begin
            wdata_r <= s_wdata_i;
            wstrb_r <= s_wstrb_i;
         end
      end
   end

   // Answers: write one cycle after both halves held, read right after address
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         bvalid_r <= 1'b0;
         rvalid_r <= 1'b0;
         bresp_r <= RSS_RESP_OKAY;
         rresp_r <= RSS_RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end
      else
      begin
         bvalid_r <= wr_go | (bvalid_r & ~s_bready_i);
         rvalid_r <= ar_take | (rvalid_r & ~s_rready_i);
         if (wr_go)
            bresp_r <= wr_hit_i ? RSS_RESP_OKAY : RSS_RESP_DECERR;
         if (ar_take)
         begin
            rdata_r <= rd_hit_i ? rd_data_i : 32'h0000_0000;
            rresp_r <= rd_hit_i ? RSS_RESP_OKAY : RSS_RESP_DECERR;
         end
      end
   end

endmodule

// ==== core/rss_pkg.sv ====
// Shared types of the request source selector
package rss_pkg;

   // Register byte
   typedef logic [7:0] rss_byte_t;

   // Bus response codes
   typedef enum logic [1:0]
   {
      RSS_RESP_OKAY = 2'b00,
      RSS_RESP_DECERR = 2'b11
   } rss_resp_t;

   // Route vector: slots 0..10, then alt 1, 4, 5
   typedef logic [13:0] rss_route_t;

endpackage

// ==== core/rss_regs.svh ====
// Register map, reset values and field positions of the request source selector
// Function
// - Slot 0: timer A ch0, else bus ch0
// - Slot 1: timer A ch1, else bus ch1
// - Slot 2: timer A ch2, else overlay two
// - Slot 3: timer A ch3, else vertical sync
// - Slot 4: timer A ch4, else bus0 no-ack
// - Slot 5: timer B ch0, else bus1 no-ack
// - Slot 6: timer B ch1, else bus2 no-ack
// - Slot 7: timer B ch2, else bus ch2
// - Slot 8 timer B ch3; never select one
// - Slot 9 timer B ch4; never select one
// - Slot 10: timer B ch5, else overlay one
// - Alt 1 interrupt only: collision, else bus0
// - Alt 4: key input, else vertical sync
// - Alt 5: converter done, else bus1 no-ack
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RSS_ADDR_SEL_LOW 12'h000
`define RSS_ADDR_SEL_HIGH 12'h004
`define RSS_ADDR_STATE 12'h008
`define RSS_ADDR_FAULT 12'h00c

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RSS_RST_SEL_LOW 8'h00
`define RSS_RST_SEL_HIGH 8'h30

// ----------------------------------------
// Field positions in the high select register
// ----------------------------------------
`define RSS_BIT_SLOT8 0
`define RSS_BIT_SLOT9 1
`define RSS_BIT_SLOT10 2
`define RSS_BIT_ALT1 3
`define RSS_BIT_RSVD_LO 4
`define RSS_BIT_RSVD_HI 5
`define RSS_BIT_ALT4 6
`define RSS_BIT_ALT5 7

// ----------------------------------------
// Route indices, counts and the fault bit position
// ----------------------------------------
`define RSS_NUM_ROUTES 14
`define RSS_IDX_ALT1 11
`define RSS_IDX_ALT4 12
`define RSS_IDX_ALT5 13
`define RSS_BIT_FAULT 0

`endif

// ==== core/rss_top.sv ====
// Request source selector: select registers, routing and request outputs
`include "rss_regs.svh"
module rss_top
   import rss_pkg::*;
(
   input wire logic mclk_i, // System clock, 125 MHz
   input wire logic sys_rst_i, // Async reset, high
   // AXI4-Lite register port
   input wire logic [11:0] s_awaddr_i, // Write address
   input wire logic s_awvalid_i, // Write address valid
   output logic s_awready_o, // Write address ready
   input wire logic [31:0] s_wdata_i, // Write data
   input wire logic [3:0] s_wstrb_i, // Write byte enables
   input wire logic s_wvalid_i, // Write data valid
   output logic s_wready_o, // Write data ready
   output logic [1:0] s_bresp_o, // Write response
   output logic s_bvalid_o, // Write response valid
   input wire logic s_bready_i, // Write response ready
   input wire logic [11:0] s_araddr_i, // Read address
   input wire logic s_arvalid_i, // Read address valid
   output logic s_arready_o, // Read address ready
   output logic [31:0] s_rdata_o, // Read data
   output logic [1:0] s_rresp_o, // Read response
   output logic s_rvalid_o, // Read data valid
   input wire logic s_rready_i, // Read data ready
   // Peripheral request sources
   input wire logic [4:0] timer_a_ch_event_i, // Timer A channels 0..4
   input wire logic [5:0] timer_b_ch_event_i, // Timer B channels 0..5
   input wire logic [2:0] serial_bus_ch_event_i, // Serial bus channel events
   input wire logic [2:0] serial_bus_ch_noack_i, // Serial bus not-acknowledge
   input wire logic display_overlay_event_one_i, // Overlay event one
   input wire logic display_overlay_event_two_i, // Overlay event two
   input wire logic vsync_event_i, // Vertical sync event
   input wire logic key_input_event_i, // Key input event
   input wire logic adc_done_event_i, // Converter completion
   input wire logic serial_port_two_collision_i, // Serial port two collision
   // Routed requests
   output logic [10:0] slot_req_o, // Slots 0..10, interrupt and DMA
   output logic alt1_irq_o, // Alt slot 1, interrupt only
   output logic alt4_req_o, // Alt slot 4, interrupt and DMA
   output logic alt5_req_o // Alt slot 5, interrupt and DMA
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   rss_byte_t sel_low_r; // Select bits of slots 0..7
   rss_byte_t sel_high_r; // Select bits of slots 8..10 and alternates
   rss_byte_t sel_low_nxt; // Next low select
   rss_byte_t sel_high_nxt; // Next high select
   rss_route_t req_r; // Registered routed requests
   rss_route_t req_nxt; // Routed requests before the register
   rss_route_t sel_vec; // Select bit per route
   rss_route_t prim_src; // Source taken when select is 0
   rss_route_t alt_src; // Source taken when select is 1
   logic fault_r; // Sticky forbidden-setting flag
   logic fault_nxt; // Next fault flag
   logic wr_en; // Register write strobe
   logic [11:0] wr_addr; // Register write address
   logic [31:0] wr_data; // Register write data
   logic [3:0] wr_strb; // Register write enables
   logic [11:0] rd_addr; // Read decode address
   logic [31:0] rd_data; // Read decode data
   logic wr_hit; // Write address is mapped
   logic rd_hit; // Read address is mapped

   // ----------------------------------------
   // Bus front end
   // ----------------------------------------
   rss_axil_slave u_bus
   (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .s_awaddr_i(s_awaddr_i),
      .s_awvalid_i(s_awvalid_i),
      .s_awready_o(s_awready_o),
      .s_wdata_i(s_wdata_i),
      .s_wstrb_i(s_wstrb_i),
      .s_wvalid_i(s_wvalid_i),
      .s_wready_o(s_wready_o),
      .s_bresp_o(s_bresp_o),
      .s_bvalid_o(s_bvalid_o),
      .s_bready_i(s_bready_i),
      .s_araddr_i(s_araddr_i),
      .s_arvalid_i(s_arvalid_i),
      .s_arready_o(s_arready_o),
      .s_rdata_o(s_rdata_o),
      .s_rresp_o(s_rresp_o),
      .s_rvalid_o(s_rvalid_o),
      .s_rready_i(s_rready_i),
      .wr_en_o(wr_en),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data),
      .wr_strb_o(wr_strb),
      .wr_hit_i(wr_hit),
      .rd_addr_o(rd_addr),
      .rd_data_i(rd_data),
      .rd_hit_i(rd_hit)
   );

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire wr_low = wr_en & (wr_addr == `RSS_ADDR_SEL_LOW) & wr_strb[0];
   wire wr_high = wr_en & (wr_addr == `RSS_ADDR_SEL_HIGH) & wr_strb[0];
   wire wr_fault = wr_en & (wr_addr == `RSS_ADDR_FAULT) & wr_strb[0];
   assign wr_hit = (wr_addr == `RSS_ADDR_SEL_LOW) | (wr_addr == `RSS_ADDR_SEL_HIGH)
      | (wr_addr == `RSS_ADDR_STATE) | (wr_addr == `RSS_ADDR_FAULT);
   wire rd_low = (rd_addr == `RSS_ADDR_SEL_LOW);
   wire rd_high = (rd_addr == `RSS_ADDR_SEL_HIGH);
   wire rd_state = (rd_addr == `RSS_ADDR_STATE);
   wire rd_flt = (rd_addr == `RSS_ADDR_FAULT);
   assign rd_hit = rd_low | rd_high | rd_state | rd_flt;

   // Read mux: narrow registers sit in the low bits, upper bits read zero
   assign rd_data = rd_low ? {24'h00_0000, sel_low_r}
      : rd_high ? {24'h00_0000, sel_high_r}
      : rd_state ? {18'h0_0000, req_r}
      : rd_flt ? {31'h0000_0000, fault_r}
      : 32'h0000_0000;

   // ----------------------------------------
   // Register updates
   // ----------------------------------------
   // Reserved high bits are stored as written; software keeps them at one
   assign sel_low_nxt = wr_low ? wr_data[7:0] : sel_low_r;
   assign sel_high_nxt = wr_high ? wr_data[7:0] : sel_high_r;

   // A forbidden select attempt sets the flag; set wins over a clearing write
   wire fault_set = wr_high & (wr_data[`RSS_BIT_SLOT8] | wr_data[`RSS_BIT_SLOT9]);
   wire fault_clr = wr_fault & wr_data[`RSS_BIT_FAULT];
   assign fault_nxt = fault_set | (fault_r & ~fault_clr);

   // Select and fault registers
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         sel_low_r <= `RSS_RST_SEL_LOW;
         sel_high_r <= `RSS_RST_SEL_HIGH;
         fault_r <= 1'b0;
      end
      else
      begin
         sel_low_r <= sel_low_nxt;
         sel_high_r <= sel_high_nxt;
         fault_r <= fault_nxt;
      end
   end

   // ----------------------------------------
   // Source tables
   // ----------------------------------------
   // Select bit of each route, reserved bits skipped
   assign sel_vec = {sel_high_r[`RSS_BIT_ALT5], sel_high_r[`RSS_BIT_ALT4],
      sel_high_r[`RSS_BIT_ALT1], sel_high_r[`RSS_BIT_SLOT10],
      sel_high_r[`RSS_BIT_SLOT9], sel_high_r[`RSS_BIT_SLOT8], sel_low_r};

   // Sources taken with the select bit at zero
   assign prim_src = {adc_done_event_i,
      key_input_event_i,
      serial_port_two_collision_i,
      timer_b_ch_event_i,
      timer_a_ch_event_i};

   // Sources taken with the select bit at one; forbidden settings route nothing
   assign alt_src = {serial_bus_ch_noack_i[1],
      vsync_event_i,
      serial_bus_ch_event_i[0],
      display_overlay_event_one_i,
      1'b0,
      1'b0,
      serial_bus_ch_event_i[2],
      serial_bus_ch_noack_i[2],
      serial_bus_ch_noack_i[1],
      serial_bus_ch_noack_i[0],
      vsync_event_i,
      display_overlay_event_two_i,
      serial_bus_ch_event_i[1],
      serial_bus_ch_event_i[0]};

   // ----------------------------------------
   // Per-route selection
   // ----------------------------------------
   // Each route sees only its own select bit and its two sources
   genvar gi;
   generate
      for (gi = 0; gi < `RSS_NUM_ROUTES; gi = gi + 1)
      begin : g_route
         assign req_nxt[gi] = sel_vec[gi] ? alt_src[gi] : prim_src[gi];
      end
   endgenerate

   // Output register keeps the request lines glitch free
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         req_r <= 14'h0000;
      else
         req_r <= req_nxt;
   end

   // Outputs; alt slot 1 feeds only the interrupt side
   assign slot_req_o = req_r[10:0];
   assign alt1_irq_o = req_r[`RSS_IDX_ALT1];
   assign alt4_req_o = req_r[`RSS_IDX_ALT4];
   assign alt5_req_o = req_r[`RSS_IDX_ALT5];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_slot0_route: assert property ($past(!sys_rst_i) |-> slot_req_o[0] ==
      ($past(sel_low_r[0]) ? $past(serial_bus_ch_event_i[0]) : $past(timer_a_ch_event_i[0])))
      else $error("slot 0 routing wrong");
   a_slot1_route: assert property ($past(!sys_rst_i) |-> slot_req_o[1] ==
      ($past(sel_low_r[1]) ? $past(serial_bus_ch_event_i[1]) : $past(timer_a_ch_event_i[1])))
      else $error("slot 1 routing wrong");
   a_slot2_route: assert property ($past(!sys_rst_i) |-> slot_req_o[2] ==
      ($past(sel_low_r[2]) ? $past(display_overlay_event_two_i) : $past(timer_a_ch_event_i[2])))
      else $error("slot 2 routing wrong");
   a_slot3_route: assert property ($past(!sys_rst_i) |-> slot_req_o[3] ==
      ($past(sel_low_r[3]) ? $past(vsync_event_i) : $past(timer_a_ch_event_i[3])))
      else $error("slot 3 routing wrong");
   a_slot4_route: assert property ($past(!sys_rst_i) |-> slot_req_o[4] ==
      ($past(sel_low_r[4]) ? $past(serial_bus_ch_noack_i[0]) : $past(timer_a_ch_event_i[4])))
      else $error("slot 4 routing wrong");
   a_slot5_route: assert property ($past(!sys_rst_i) |-> slot_req_o[5] ==
      ($past(sel_low_r[5]) ? $past(serial_bus_ch_noack_i[1]) : $past(timer_b_ch_event_i[0])))
      else $error("slot 5 routing wrong");
   a_slot6_route: assert property ($past(!sys_rst_i) |-> slot_req_o[6] ==
      ($past(sel_low_r[6]) ? $past(serial_bus_ch_noack_i[2]) : $past(timer_b_ch_event_i[1])))
      else $error("slot 6 routing wrong");
   a_slot7_route: assert property ($past(!sys_rst_i) |-> slot_req_o[7] ==
      ($past(sel_low_r[7]) ? $past(serial_bus_ch_event_i[2]) : $past(timer_b_ch_event_i[2])))
      else $error("slot 7 routing wrong");
   a_slot8_route: assert property ($past(!sys_rst_i) |-> slot_req_o[8] ==
      (!$past(sel_high_r[`RSS_BIT_SLOT8]) && $past(timer_b_ch_event_i[3])))
      else $error("slot 8 routing wrong");
   a_slot9_route: assert property ($past(!sys_rst_i) |-> slot_req_o[9] ==
      (!$past(sel_high_r[`RSS_BIT_SLOT9]) && $past(timer_b_ch_event_i[4])))
      else $error("slot 9 routing wrong");
   a_slot10_route: assert property ($past(!sys_rst_i) |-> slot_req_o[10] ==
      ($past(sel_high_r[2]) ? $past(display_overlay_event_one_i) : $past(timer_b_ch_event_i[5])))
      else $error("slot 10 routing wrong");
   a_alt1_route: assert property ($past(!sys_rst_i) |-> alt1_irq_o ==
      ($past(sel_high_r[3]) ? $past(serial_bus_ch_event_i[0])
      : $past(serial_port_two_collision_i)))
      else $error("alt 1 routing wrong");
   a_alt4_route: assert property ($past(!sys_rst_i) |-> alt4_req_o ==
      ($past(sel_high_r[6]) ? $past(vsync_event_i) : $past(key_input_event_i)))
      else $error("alt 4 routing wrong");
   a_alt5_route: assert property ($past(!sys_rst_i) |-> alt5_req_o ==
      ($past(sel_high_r[7]) ? $past(serial_bus_ch_noack_i[1]) : $past(adc_done_event_i)))
      else $error("alt 5 routing wrong");
   a_sel_isolate: assert property (wr_low && !wr_high |=> $stable(sel_high_r))
      else $error("low write disturbed high select");
   a_fault_sticky: assert property (fault_set
      |=> fault_r ##1 (fault_r || $past(fault_clr)))
      else $error("forbidden setting flag lost");

   // Writes land at the next edge
   a_low_write: assert property (wr_low
      |=> sel_low_r == $past(wr_data[7:0]))
      else $error("low select write lost");
   a_high_write: assert property (wr_high
      |=> sel_high_r == $past(wr_data[7:0]))
      else $error("high select write lost");

   // Selects move only on their own write
   a_low_hold: assert property (!wr_low
      |=> $stable(sel_low_r))
      else $error("low select moved");
   a_high_hold: assert property (!wr_high
      |=> $stable(sel_high_r))
      else $error("high select moved");

   // Flag clears on request, holds otherwise
   a_fault_clear: assert property (fault_clr && !fault_set
      |=> !fault_r)
      else $error("fault flag not cleared");
   a_fault_hold: assert property (fault_r && !fault_clr
      |=> fault_r)
      else $error("fault flag dropped");

   // Forbidden selects keep slots 8 and 9 quiet
   a_slot8_quiet: assert property (sel_high_r[`RSS_BIT_SLOT8]
      |=> !slot_req_o[8])
      else $error("slot 8 not quiet");
   a_slot9_quiet: assert property (sel_high_r[`RSS_BIT_SLOT9]
      |=> !slot_req_o[9])
      else $error("slot 9 not quiet");

   // Bus answers one cycle after strobe or address
   a_write_answer: assert property (wr_en
      |=> s_bvalid_o)
      else $error("write answer late");
   a_read_answer: assert property (s_arvalid_i && s_arready_o
      |=> s_rvalid_o)
      else $error("read answer late");

endmodule

// ==== tb/rss_req_sink.sv ====
// Model of the interrupt controller and DMA trigger logic fed by the selector
module rss_req_sink
   import rss_pkg::*;
(
   input wire logic mclk_i, // System clock
   input wire logic sys_rst_i, // Async reset, high
   input wire logic [10:0] slot_req_i, // Routed slots 0..10
   input wire logic alt1_irq_i, // Alt slot 1, interrupt only
   input wire logic alt4_req_i, // Alt slot 4
   input wire logic alt5_req_i, // Alt slot 5
   output rss_route_t seen_o, // Requests as the consumer sees them
   output logic [13:0] dma_seen_o // Requests that may start a DMA transfer
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Request capture
   // ----------------------------------------
   // Consumer samples on the clock, as the DMA trigger logic would
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         dma_seen_o <= '0;
      else
         dma_seen_o <= {alt5_req_i, alt4_req_i, 1'b0, slot_req_i};
   end
   // Level view of every slot
   assign seen_o = {alt5_req_i, alt4_req_i, alt1_irq_i, slot_req_i};
endmodule

// ==== tb/rss_top_tb.sv ====
// Self-checking bench of the request source selector
`include "rss_regs.svh"
module rss_top_tb
   import rss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Bench signals
   // ----------------------------------------
   logic mclk = 1'b0; // 125 MHz clock
   logic sys_rst = 1'b1; // Reset, high
   logic [11:0] awaddr = '0; // Write address
   logic [11:0] araddr = '0; // Read address
   logic [31:0] wdata = '0; // Write data
   logic [3:0] wstrb = '0; // Write enables
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid; // Slave handshakes
   logic [1:0] bresp, rresp; // Responses
   logic [31:0] rdata; // Read data
   logic [22:0] src = '0; // All request sources
   logic [10:0] slot_req; // Routed slots
   logic alt1, alt4, alt5; // Alt slots
   rss_route_t seen; // Consumer view
   logic [13:0] dma_seen; // Consumer DMA view
   logic [7:0] corner [4] = '{8'h00, 8'hff, 8'h55, 8'haa}; // Corner selections
   int err_total = 0;
   int num_checks = 0;
   always #4 mclk = ~mclk;
   // ----------------------------------------
   // Design and far side
   // ----------------------------------------
   rss_top u_dut (.mclk_i(mclk), .sys_rst_i(sys_rst), .s_awaddr_i(awaddr),
      .s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(wstrb),
      .s_wvalid_i(wvalid), .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid),
      .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
      .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid),
      .s_rready_i(rready), .timer_a_ch_event_i(src[4:0]), .timer_b_ch_event_i(src[10:5]),
      .serial_bus_ch_event_i(src[13:11]), .serial_bus_ch_noack_i(src[16:14]),
      .display_overlay_event_one_i(src[17]), .display_overlay_event_two_i(src[18]),
      .vsync_event_i(src[19]), .key_input_event_i(src[20]), .adc_done_event_i(src[21]),
      .serial_port_two_collision_i(src[22]), .slot_req_o(slot_req), .alt1_irq_o(alt1),
      .alt4_req_o(alt4), .alt5_req_o(alt5));
   rss_req_sink u_sink (.mclk_i(mclk), .sys_rst_i(sys_rst), .slot_req_i(slot_req),
      .alt1_irq_i(alt1), .alt4_req_i(alt4), .alt5_req_i(alt5), .seen_o(seen),
      .dma_seen_o(dma_seen));
   // ----------------------------------------
   // Expected routing
   // ----------------------------------------
   function automatic rss_route_t exp_route(logic [7:0] lo, logic [7:0] hi, logic [22:0] s);
      rss_route_t r;
      r[0] = lo[0] ? s[11] : s[0];
      r[1] = lo[1] ? s[12] : s[1];
      r[2] = lo[2] ? s[18] : s[2];
      r[3] = lo[3] ? s[19] : s[3];
      r[4] = lo[4] ? s[14] : s[4];
      r[5] = lo[5] ? s[15] : s[5];
      r[6] = lo[6] ? s[16] : s[6];
      r[7] = lo[7] ? s[13] : s[7];
      r[8] = hi[0] ? 1'b0 : s[8];
      r[9] = hi[1] ? 1'b0 : s[9];
      r[10] = hi[2] ? s[17] : s[10];
      r[11] = hi[3] ? s[11] : s[22];
      r[12] = hi[6] ? s[19] : s[20];
      r[13] = hi[7] ? s[15] : s[21];
      return r;
   endfunction
   // ----------------------------------------
   // Compare and bus tasks
   // ----------------------------------------
   task automatic chk_val(input logic [31:0] e, input logic [31:0] g, input string what);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("Error at %0t: %s got %h want %h", $time, what, g, e);
      end
   endtask
   task automatic chk_resp(input logic [1:0] e, input logic [1:0] g);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("Error at %0t: response %b want %b", $time, g, e);
      end
   endtask
   // Write with address and data offered together, held until taken
   task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
      input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] rsp;
      int n;
      n = 0;
      tb = 1'b0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb && n < 50)
      begin
         @(negedge mclk);
         ta = awvalid & (awready === 1'b1);
         tw = wvalid & (wready === 1'b1);
         tb = bready & (bvalid === 1'b1);
         rsp = bresp;
         @(posedge mclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
         n++;
      end
      if (tb) chk_resp(er, rsp);
      else chk_val(32'h1, 32'h0, "write answer");
   endtask
   // Read held until taken, data sampled at the falling edge while the answer is valid
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ta, tr;
      logic [31:0] d;
      logic [1:0] rsp;
      int n;
      n = 0;
      tr = 1'b0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tr && n < 50)
      begin
         @(negedge mclk);
         ta = arvalid & (arready === 1'b1);
         tr = rready & (rvalid === 1'b1);
         d = rdata;
         rsp = rresp;
         @(posedge mclk);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
         n++;
      end
      chk_val(ed, tr ? d : 32'hx, "read data");
      chk_resp(er, rsp);
   endtask
   task automatic stop_test;
      $display("Checks %0d, errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      logic [7:0] lo, hi;
      rss_route_t ex;
      lo = 8'h00;
      void'($urandom(82753));
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      rd_chk(`RSS_ADDR_SEL_LOW, 32'h00, RSS_RESP_OKAY);
      rd_chk(`RSS_ADDR_SEL_HIGH, 32'h30, RSS_RESP_OKAY);
      rd_chk(`RSS_ADDR_FAULT, 32'h0, RSS_RESP_OKAY);
      // Unmapped place and a write with its byte disabled
      wr_chk(12'h010, 32'hff, 4'hf, RSS_RESP_DECERR);
      rd_chk(12'h010, 32'h0, RSS_RESP_DECERR);
      wr_chk(`RSS_ADDR_SEL_LOW, 32'hff, 4'h0, RSS_RESP_OKAY);
      rd_chk(`RSS_ADDR_SEL_LOW, 32'h00, RSS_RESP_OKAY);
      // Corner then random selections, sources changed under each
      for (int i = 0; i < 40; i++)
      begin
         lo = (i < 4) ? corner[i] : 8'($urandom);
         hi = (((i < 4) ? corner[i] : 8'($urandom)) & 8'hcc) | 8'h30;
         wr_chk(`RSS_ADDR_SEL_LOW, {24'h0, lo}, 4'hf, RSS_RESP_OKAY);
         wr_chk(`RSS_ADDR_SEL_HIGH, {24'h0, hi}, 4'h1, RSS_RESP_OKAY);
         rd_chk(`RSS_ADDR_SEL_HIGH, {24'h0, hi}, RSS_RESP_OKAY);
         for (int j = 0; j < 4; j++)
         begin
            @(posedge mclk);
            src <= (j == 3) ? ~src : 23'($urandom);
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            ex = exp_route(lo, hi, src);
            chk_val(32'(ex[7:0]), 32'(seen[7:0]), "low");
            chk_val(32'(ex[13:8]), 32'(seen[13:8]), "high");
            chk_val(32'(ex & 14'h37ff), 32'(dma_seen), "dma");
         end
         rd_chk(`RSS_ADDR_STATE, 32'(ex), RSS_RESP_OKAY);
      end
      // Forbidden selection on slots 8 and 9 keeps them quiet and is flagged
      @(posedge mclk);
      src <= '1;
      wr_chk(`RSS_ADDR_SEL_HIGH, 32'h33, 4'h1, RSS_RESP_OKAY);
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk_val(32'(exp_route(lo, 8'h33, src)), 32'(seen), "forbidden");
      rd_chk(`RSS_ADDR_FAULT, 32'h1, RSS_RESP_OKAY);
      wr_chk(`RSS_ADDR_FAULT, 32'h1, 4'h1, RSS_RESP_OKAY);
      rd_chk(`RSS_ADDR_FAULT, 32'h0, RSS_RESP_OKAY);
      stop_test;
   end
   // Watchdog well beyond the expected thousand or so cycles
   initial
   begin
      repeat (20000) @(posedge mclk);
      err_total++;
      $display("Error at %0t: watchdog expired", $time);
      stop_test;
   end
endmodule
